// ### shared/itc_pkg.sv
// interrupt and trap control package: register map, field positions, resets
// assumes a 32-bit apb slave with each register on one aligned word
// Function
// - address fault flag at control one bit 3
// - stack fault flag at control one bit 2
// - oscillator fault flag at control one bit 1
// - unimplemented bits always read as zero
// - global gate resets one, blocks user interrupts only, not the event irq
// - hold bit shows disable instruction active
// - soft trap control bit, resets zero
// - edge select bits, one means falling edge
// - dma address fault flag at control three bit 5
// - loop stack overflow flag at control three bit 4
// - soft hard trap flag at control four bit 0
// - pending priority level, read only, bits 11-8
// - pending vector number minus eight, bits 6-0
// - request flags set by hardware, cleared by software
// - each user source has one of eight levels
// - cpu priority high bit read only, masks users
`default_nettype none
package itc_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_CTL_ONE     = 8'h00;
    localparam logic [7:0]  OFS_CTL_TWO     = 8'h04;
    localparam logic [7:0]  OFS_CTL_THREE   = 8'h08;
    localparam logic [7:0]  OFS_CTL_FOUR    = 8'h0c;
    localparam logic [7:0]  OFS_PEND_VEC    = 8'h10;
    localparam logic [7:0]  OFS_REQ_FLAGS   = 8'h14;
    localparam logic [7:0]  OFS_REQ_EN      = 8'h18;
    localparam logic [7:0]  OFS_PRIO        = 8'h1c;
    localparam logic [7:0]  OFS_EVT_STAT    = 8'h20;
    localparam logic [7:0]  OFS_EVT_CLR     = 8'h24;
    localparam logic [7:0]  OFS_EVT_EN      = 8'h28;
    localparam logic [7:0]  OFS_CPU_LVL     = 8'h2c;
    // control one
    localparam int          B_ADDR_FAULT    = 3;
    localparam int          B_STACK_FAULT   = 2;
    localparam int          B_OSC_FAULT     = 1;
    // control two
    localparam int          B_GLOBAL_GATE   = 15;
    localparam int          B_IRQ_HOLD      = 14;
    localparam int          B_SOFT_TRAP     = 13;
    localparam int          B_EXT2_EDGE     = 2;
    localparam int          B_EXT0_EDGE     = 0;
    localparam int          N_EXT           = 3;
    // control three and four
    localparam int          B_DMA_FAULT     = 5;
    localparam int          B_LOOP_OVF      = 4;
    localparam int          B_SOFT_HARD     = 0;
    // pending vector status
    localparam int          B_LVL_LO        = 8;
    localparam int          LVL_W           = 4;
    localparam int          VEC_W           = 7;
    localparam int          PRIO_W          = 3;
    localparam int          IPL_W           = 3;
    localparam logic        GATE_RST        = 1'b1;
    localparam logic [2:0]  EDGE_RST        = 3'h0;
    // event status layout, one bit per trap flag
    localparam int          N_EVT           = 6;
    localparam int          E_ADDR          = 0;
    localparam int          E_STACK         = 1;
    localparam int          E_OSC           = 2;
    localparam int          E_DMA           = 3;
    localparam int          E_LOOP          = 4;
    localparam int          E_SOFT_HARD     = 5;

    typedef struct packed {
        logic addrFault;
        logic stackFault;
        logic oscFault;
        logic dmaFault;
        logic loopOverflow;
        logic softHardTrap;
    } itc_trap_s;

    typedef struct packed {
        logic [LVL_W-1:0] level;
        logic [VEC_W-1:0] vector;
    } itc_pend_s;
endpackage
`default_nettype wire

// ### src/itc_regs.sv
// interrupt and trap control/status registers with pending vector selection
// assumes an apb master on clk; trap and request inputs are one-cycle pulses
//
// Decided for this implementation: the placing of the registers and the APB register port.
`default_nettype none
module itc_regs #(
    parameter int NSRC = 8
) (
    input  wire logic                            clk,         // 200 MHz clock
    input  wire logic                            srst,        // sync reset
    input  wire logic                            psel,        // apb select
    input  wire logic                            penable,     // apb enable
    input  wire logic                            pwrite,      // apb direction
    input  wire logic [itc_pkg::ADDR_W-1:0]      paddr,       // apb byte address
    input  wire logic [31:0]                     pwdata,      // apb write data
    output logic                                 pready,      // apb ready
    output logic [31:0]                          prdata,      // apb read data
    output logic                                 pslverr,     // apb error
    input  wire itc_pkg::itc_trap_s              trapEvt,     // trap pulses
    input  wire logic                            irqHoldIn,   // disable instr active
    input  wire logic [itc_pkg::N_EXT-1:0]       extIrq,      // external irq pins
    input  wire logic [NSRC-1:0]                 srcEvt,      // peripheral pulses
    input  wire logic [itc_pkg::IPL_W-1:0]       cpuIpl,      // cpu level low bits
    input  wire logic                            cpuIplHigh,  // cpu level bit 3
    output logic                                 globalGate,  // global enable
    output logic                                 softTrapEn,  // soft trap control
    output logic                                 irqPending,  // user irq to core
    output itc_pkg::itc_pend_s                   pendInfo,    // level and vector
    output logic                                 irq          // event interrupt
);
    import itc_pkg::*;

    // refuse source counts that the pin map or the priority word cannot serve
    generate
        if (NSRC < N_EXT) begin : g_few_src
            $error("itc_regs: NSRC must cover the external pins");
        end
        if (NSRC > 8) begin : g_many_src
            $error("itc_regs: NSRC above 8 is not supported");
        end
    endgenerate

    logic                   setupRd;
    logic                   wrEn;
    logic [31:0]            rdMux;
    logic                   rdHit;
    logic [N_EXT-1:0]       extEdge;
    logic [NSRC-1:0]        reqSet;
    logic [N_EVT-1:0]       trapSet;
    logic [PRIO_W-1:0]      srcPrio [NSRC];

    // trap flags
    logic [N_EVT-1:0]       trap_q, trap_d;
    // control two
    logic                   gate_q, gate_d;
    logic                   soft_q, soft_d;
    logic [N_EXT-1:0]       edge_q, edge_d;
    logic [N_EXT-1:0]       extPrev_q, extPrev_d;
    // user sources
    logic [NSRC-1:0]        reqFlag_q, reqFlag_d;
    logic [NSRC-1:0]        reqEn_q, reqEn_d;
    logic [NSRC*PRIO_W-1:0] prio_q, prio_d;
    // interrupt event registers
    logic [N_EVT-1:0]       evtStat_q, evtStat_d;
    logic [N_EVT-1:0]       evtEn_q, evtEn_d;
    // pending and bus answer
    itc_pend_s              pend_q, pend_d;
    logic                   pendValid_q, pendValid_d;
    logic [31:0]            rdata_q, rdata_d;
    logic                   err_q, err_d;

    assign setupRd = psel & ~penable;
    assign wrEn    = psel & penable & pwrite;
    assign trapSet = {trapEvt.softHardTrap, trapEvt.loopOverflow, trapEvt.dmaFault,
                      trapEvt.oscFault, trapEvt.stackFault, trapEvt.addrFault};

    // edge detect per external pin, polarity from the select bit
    genvar gi;
    generate
        for (gi = 0; gi < N_EXT; gi++) begin : g_ext
            assign extEdge[gi] = edge_q[gi] ? (extPrev_q[gi] & ~extIrq[gi])
                                            : (~extPrev_q[gi] & extIrq[gi]);
        end
    endgenerate

    // per-source priority slice
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            assign srcPrio[gi] = prio_q[gi*PRIO_W +: PRIO_W];
        end
    endgenerate

    always_comb begin
        reqSet = srcEvt;
        reqSet[N_EXT-1:0] = srcEvt[N_EXT-1:0] | extEdge;
    end

    // read mux; unimplemented bits stay zero
    always_comb begin
        rdMux = 32'h0;
        rdHit = 1'b1;
        case (paddr)
            OFS_CTL_ONE: begin
                rdMux[B_ADDR_FAULT]  = trap_q[E_ADDR];
                rdMux[B_STACK_FAULT] = trap_q[E_STACK];
                rdMux[B_OSC_FAULT]   = trap_q[E_OSC];
            end
            OFS_CTL_TWO: begin
                rdMux[B_GLOBAL_GATE] = gate_q;
                rdMux[B_IRQ_HOLD]    = irqHoldIn;
                rdMux[B_SOFT_TRAP]   = soft_q;
                rdMux[B_EXT2_EDGE:B_EXT0_EDGE] = edge_q;
            end
            OFS_CTL_THREE: begin
                rdMux[B_DMA_FAULT] = trap_q[E_DMA];
                rdMux[B_LOOP_OVF]  = trap_q[E_LOOP];
            end
            OFS_CTL_FOUR: begin
                rdMux[B_SOFT_HARD] = trap_q[E_SOFT_HARD];
            end
            OFS_PEND_VEC: begin
                rdMux[B_LVL_LO +: LVL_W] = pend_q.level;
                rdMux[VEC_W-1:0]         = pend_q.vector;
            end
            OFS_REQ_FLAGS: rdMux[NSRC-1:0]        = reqFlag_q;
            OFS_REQ_EN:    rdMux[NSRC-1:0]        = reqEn_q;
            OFS_PRIO:      rdMux[NSRC*PRIO_W-1:0] = prio_q;
            OFS_EVT_STAT:  rdMux[N_EVT-1:0]       = evtStat_q;
            OFS_EVT_CLR:   rdMux                  = 32'h0;
            OFS_EVT_EN:    rdMux[N_EVT-1:0]       = evtEn_q;
            OFS_CPU_LVL:   rdMux[IPL_W:0]         = {cpuIplHigh, cpuIpl};
            default:       rdHit                  = 1'b0;
        endcase
    end

    // trap flags; hardware set wins over a same-cycle software clear
    always_comb begin
        trap_d = trap_q;
        if (wrEn) begin
            case (paddr)
                OFS_CTL_ONE: begin
                    trap_d[E_ADDR]  = trap_q[E_ADDR]  & pwdata[B_ADDR_FAULT];
                    trap_d[E_STACK] = trap_q[E_STACK] & pwdata[B_STACK_FAULT];
                    trap_d[E_OSC]   = trap_q[E_OSC]   & pwdata[B_OSC_FAULT];
                end
                OFS_CTL_THREE: begin
                    trap_d[E_DMA]  = trap_q[E_DMA]  & pwdata[B_DMA_FAULT];
                    trap_d[E_LOOP] = trap_q[E_LOOP] & pwdata[B_LOOP_OVF];
                end
                OFS_CTL_FOUR: begin
                    trap_d[E_SOFT_HARD] = trap_q[E_SOFT_HARD] & pwdata[B_SOFT_HARD];
                end
                default: begin
                end
            endcase
        end
        trap_d = trap_d | trapSet;
    end

    // control two; the hold bit comes from the core and is never stored
    always_comb begin
        gate_d = gate_q;
        soft_d = soft_q;
        edge_d = edge_q;
        if (wrEn && paddr == OFS_CTL_TWO) begin
            gate_d = pwdata[B_GLOBAL_GATE];
            soft_d = pwdata[B_SOFT_TRAP];
            edge_d = pwdata[B_EXT2_EDGE:B_EXT0_EDGE];
        end
    end

    // previous pin sample for the edge detectors
    always_comb begin
        extPrev_d = extIrq;
    end

    // user request flags; a same-cycle event wins over the clear
    always_comb begin
        reqFlag_d = reqFlag_q;
        if (wrEn && paddr == OFS_REQ_FLAGS) begin
            reqFlag_d = reqFlag_q & pwdata[NSRC-1:0];
        end
        reqFlag_d = reqFlag_d | reqSet;
    end

    // user enables
    always_comb begin
        reqEn_d = reqEn_q;
        if (wrEn && paddr == OFS_REQ_EN) begin
            reqEn_d = pwdata[NSRC-1:0];
        end
    end

    // three priority bits per source, source zero lowest
    always_comb begin
        prio_d = prio_q;
        if (wrEn && paddr == OFS_PRIO) begin
            prio_d = pwdata[NSRC*PRIO_W-1:0];
        end
    end

    // event status; a same-cycle trap wins over the clear
    always_comb begin
        evtStat_d = evtStat_q;
        if (wrEn && paddr == OFS_EVT_CLR) begin
            evtStat_d = evtStat_q & ~pwdata[N_EVT-1:0];
        end
        evtStat_d = evtStat_d | trapSet;
    end

    // event enables
    always_comb begin
        evtEn_d = evtEn_q;
        if (wrEn && paddr == OFS_EVT_EN) begin
            evtEn_d = pwdata[N_EVT-1:0];
        end
    end

    // pending selection: highest level, lowest index on a tie
    always_comb begin
        logic [PRIO_W-1:0] bestLvl;
        logic [VEC_W-1:0]  bestVec;
        logic              found;
        logic              blocked;
        bestLvl     = '0;
        bestVec     = '0;
        found       = 1'b0;
        pend_d      = pend_q;
        // only user requests are gated here; traps never pass this path
        blocked     = ~gate_q | irqHoldIn | cpuIplHigh;
        for (int i = 0; i < NSRC; i++) begin
            if (reqFlag_q[i] && reqEn_q[i] && (srcPrio[i] > cpuIpl)
                && (!found || srcPrio[i] > bestLvl)) begin
                found   = 1'b1;
                bestLvl = srcPrio[i];
                bestVec = VEC_W'(i);
            end
        end
        pendValid_d = found & ~blocked;
        if (pendValid_d) begin
            pend_d.level  = {1'b0, bestLvl};
            pend_d.vector = bestVec;
        end
    end

    // bus answer captured in the setup cycle
    always_comb begin
        rdata_d = setupRd ? rdMux : rdata_q;
    end

    always_comb begin
        err_d = setupRd ? ~rdHit : err_q;
    end

    // trap and control two state
    always_ff @(posedge clk) begin
        if (srst) begin
            trap_q <= '0;
        end else begin
            trap_q <= trap_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gate_q <= GATE_RST;
        end else begin
            gate_q <= gate_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= soft_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            edge_q <= EDGE_RST;
        end else begin
            edge_q <= edge_d;
        end
    end

    // no reset: tracking the pins through reset avoids a false edge after it
    always_ff @(posedge clk) begin
        extPrev_q <= extPrev_d;
    end

    // user source state
    always_ff @(posedge clk) begin
        if (srst) begin
            reqFlag_q <= '0;
        end else begin
            reqFlag_q <= reqFlag_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reqEn_q <= '0;
        end else begin
            reqEn_q <= reqEn_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prio_q <= '0;
        end else begin
            prio_q <= prio_d;
        end
    end

    // event state
    always_ff @(posedge clk) begin
        if (srst) begin
            evtStat_q <= '0;
        end else begin
            evtStat_q <= evtStat_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            evtEn_q <= '0;
        end else begin
            evtEn_q <= evtEn_d;
        end
    end

    // pending and bus answer state
    always_ff @(posedge clk) begin
        if (srst) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pendValid_q <= 1'b0;
        end else begin
            pendValid_q <= pendValid_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            err_q <= 1'b0;
        end else begin
            err_q <= err_d;
        end
    end

    assign pready     = 1'b1;
    assign prdata     = rdata_q;
    assign pslverr    = psel & penable & err_q;
    assign globalGate = gate_q;
    assign softTrapEn = soft_q;
    assign irqPending = pendValid_q;
    assign pendInfo   = pend_q;
    assign irq        = |(evtStat_q & evtEn_q);
endmodule
`default_nettype wire

// ### tb/itc_partner.sv
// partner: core and peripherals, one-cycle trap and source pulses on command
// assumes commands are driven just after a rising clk edge
`default_nettype none
module itc_partner (
    input  wire logic               clk,     // clock
    input  wire logic               srst,    // sync reset
    input  wire logic [5:0]         trapCmd, // trap command
    input  wire logic [7:0]         srcCmd,  // source command
    output var  itc_pkg::itc_trap_s trapEvt, // trap pulses
    output var  logic [7:0]         srcEvt   // source pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    import itc_pkg::*;
    always_ff @(posedge clk) begin
        trapEvt <= srst ? '0 : trapCmd;
        srcEvt  <= srst ? '0 : srcCmd;
    end
endmodule
`default_nettype wire

// ### tb/itc_chk.sv
// checker for itc_regs: read-back shapes, gate and level masking
// assumes a bind to itc_regs with ports of the same names
`default_nettype none
module itc_chk (
    input wire logic                        clk,        // clock
    input wire logic                        srst,       // sync reset
    input wire logic                        psel,       // apb select
    input wire logic                        penable,    // apb enable
    input wire logic                        pwrite,     // apb direction
    input wire logic [itc_pkg::ADDR_W-1:0]  paddr,      // apb address
    input wire logic [31:0]                 pwdata,     // write data
    input wire logic [31:0]                 prdata,     // read data
    input wire logic                        irqHoldIn,  // hold active
    input wire logic                        cpuIplHigh, // level bit 3
    input wire logic [itc_pkg::IPL_W-1:0]   cpuIpl,     // level low bits
    input wire logic                        globalGate, // global gate
    input wire logic                        softTrapEn, // soft trap
    input wire logic                        irqPending, // user irq
    input wire itc_pkg::itc_pend_s          pendInfo,   // level, vector
    input wire logic                        irq         // event irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import itc_pkg::*;
    logic rdStp;
    logic wrAcc;
    assign rdStp = psel && !penable && !pwrite;
    assign wrAcc = psel && penable && pwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    rst_vals_a: assert property ($fell(srst) |-> globalGate && !softTrapEn && !irq)
        else $error("reset values wrong");
    two_write_a: assert property (wrAcc && paddr == OFS_CTL_TWO |=>
        globalGate == $past(pwdata[15]) && softTrapEn == $past(pwdata[13]))
        else $error("control two write lost");
    gate_block_a: assert property (!globalGate |=> !irqPending)
        else $error("pending while gate closed");
    high_mask_a: assert property (cpuIplHigh |=> !irqPending)
        else $error("pending above level seven");
    hold_read_a: assert property (rdStp && paddr == OFS_CTL_TWO |=>
        prdata[14] == $past(irqHoldIn) && prdata[12:3] == 10'h0 && prdata[31:16] == 16'h0)
        else $error("control two read wrong");
    pend_read_a: assert property (rdStp && paddr == OFS_PEND_VEC |=> prdata ==
        {20'h0, $past(pendInfo.level), 1'b0, $past(pendInfo.vector)})
        else $error("pending vector read wrong");
    lvl_range_a: assert property (irqPending |-> !pendInfo.level[3] &&
        pendInfo.level[2:0] > $past(cpuIpl))
        else $error("user level wrong for cpu level");
    four_read_a: assert property (rdStp && paddr == OFS_CTL_FOUR |=> prdata[31:1] == 31'h0)
        else $error("control four spare bits set");
endmodule
`default_nettype wire

// ### tb/itc_regs_bench.sv
// bench for itc_regs: apb master, register model, trap, pending and edge scenarios
// assumes itc_pkg, itc_partner and itc_chk are compiled first
`default_nettype none
module itc_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import itc_pkg::*;
    logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic        irqHoldIn = 0, cpuIplHigh = 0, pready, pslverr, mGate = 1, mSoft = 0;
    logic        globalGate, softTrapEn, irqPending, irq;
    logic [7:0]  paddr = 0, srcCmd = 0, srcEvt;
    logic [31:0] pwdata = 0, prdata, rd, d;
    logic [2:0]  extIrq = 0, cpuIpl = 0, mEdge = 0;
    logic [5:0]  trapCmd = 0, mTrap = 0, mEvt = 0;
    itc_trap_s   trapEvt;
    itc_pend_s   pendInfo;
    int          n_errors = 0, num_checks = 0, s, p;
    logic [7:0]  regs [5] = '{OFS_CTL_ONE, OFS_CTL_TWO, OFS_CTL_THREE, OFS_CTL_FOUR, OFS_EVT_STAT};
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", n, e, v); end end
    itc_partner part (.clk(clk), .srst(srst), .trapCmd(trapCmd), .srcCmd(srcCmd),
        .trapEvt(trapEvt), .srcEvt(srcEvt));
    itc_regs #(.NSRC(8)) uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .trapEvt(trapEvt), .irqHoldIn(irqHoldIn), .extIrq(extIrq),
        .srcEvt(srcEvt), .cpuIpl(cpuIpl), .cpuIplHigh(cpuIplHigh), .globalGate(globalGate),
        .softTrapEn(softTrapEn), .irqPending(irqPending), .pendInfo(pendInfo), .irq(irq));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] expReg(logic [7:0] a);
        case (a)
            OFS_CTL_ONE:   return {28'h0, mTrap[0], mTrap[1], mTrap[2], 1'b0};
            OFS_CTL_TWO:   return {16'h0, mGate, irqHoldIn, mSoft, 10'h0, mEdge};
            OFS_CTL_THREE: return {26'h0, mTrap[3], mTrap[4], 4'h0};
            OFS_CTL_FOUR:  return {31'h0, mTrap[5]};
            default:       return {26'h0, mEvt};
        endcase
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chkAll();
        foreach (regs[j]) begin
            apb(1'b0, regs[j], 32'h0);
            `CHK("reg", expReg(regs[j]), rd)
        end
    endtask
    // one-cycle command, then let flags and pending settle
    task automatic pulse(input logic [5:0] t, input logic [7:0] sv);
        @(posedge clk);
        trapCmd <= t;
        srcCmd  <= sv;
        @(posedge clk);
        trapCmd <= 6'h0;
        srcCmd  <= 8'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #20us;
        n_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(70826));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        chkAll();
        apb(1'b0, OFS_PEND_VEC, 32'h0);
        `CHK("pend", 32'h0, rd)
        apb(1'b1, OFS_EVT_EN, 32'h3f);
        for (int i = 0; i < N_EVT; i++) begin
            pulse(6'h20 >> i, 8'h0);
            mTrap[i] = 1'b1;
            mEvt[i] = 1'b1;
            chkAll();
            `CHK("irq", 1'b1, irq)
        end
        apb(1'b1, OFS_CTL_ONE, 32'hffffffff);
        chkAll();
        apb(1'b1, OFS_CTL_ONE, 32'h0);
        apb(1'b1, OFS_CTL_THREE, 32'h0);
        apb(1'b1, OFS_CTL_FOUR, 32'h0);
        apb(1'b1, OFS_EVT_CLR, 32'h3f);
        mTrap = 6'h0;
        mEvt = 6'h0;
        chkAll();
        `CHK("irq", 1'b0, irq)
        repeat (4) begin
            d = $urandom;
            apb(1'b1, OFS_CTL_TWO, d);
            {mGate, mSoft, mEdge} = {d[15], d[13], d[2:0]};
            irqHoldIn <= ~irqHoldIn;
            chkAll();
            `CHK("gate", {mGate, mSoft}, {globalGate, softTrapEn})
        end
        apb(1'b1, OFS_CTL_TWO, 32'h8000);
        {mGate, mSoft, mEdge} = 5'h10;
        s = $urandom_range(7, 3);
        p = $urandom_range(7, 1);
        cpuIpl <= 3'(p - 1);
        apb(1'b1, OFS_REQ_EN, 32'h1 << s);
        apb(1'b1, OFS_PRIO, 32'(p) << (3 * s));
        pulse(6'h0, 8'(1 << s));
        apb(1'b0, OFS_REQ_FLAGS, 32'h0);
        `CHK("flags", 32'h1 << s, rd)
        `CHK("pending", 1'b1, irqPending)
        apb(1'b0, OFS_PEND_VEC, 32'h0);
        `CHK("vector", 32'((p << 8) | s), rd)
        cpuIplHigh <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("masked", 1'b0, irqPending)
        apb(1'b0, OFS_CPU_LVL, 32'h0);
        `CHK("cpu level", 32'(p + 7), rd)
        cpuIplHigh <= 1'b0;
        apb(1'b1, OFS_CTL_TWO, 32'h0);
        repeat (3) @(posedge clk);
        `CHK("gated", 1'b0, irqPending)
        apb(1'b1, OFS_REQ_FLAGS, 32'h0);
        apb(1'b1, OFS_CTL_TWO, 32'h8001);
        extIrq <= 3'b001;
        repeat (3) @(posedge clk);
        extIrq <= 3'b010;
        repeat (3) @(posedge clk);
        apb(1'b0, OFS_REQ_FLAGS, 32'h0);
        `CHK("edges", 32'h3, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 2'b10, {err, |rd})
        end_of_test();
    end
endmodule
bind itc_regs itc_chk chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .irqHoldIn(irqHoldIn),
    .cpuIplHigh(cpuIplHigh), .cpuIpl(cpuIpl), .globalGate(globalGate), .softTrapEn(softTrapEn),
    .irqPending(irqPending), .pendInfo(pendInfo), .irq(irq));
`default_nettype wire
